// [crbf_pkg.sv]
// Constants and types for the return, bit and flag instruction unit
// How it works
// - Port clear drives D bit Y low
// - Subroutine return pops program counter, two cycles
// - Interrupt return pops program counter in one cycle
// - Interrupt return restores X, Y, Z, flags
// - Interrupt return restores NOP status, A, B
// - Return-and-skip pops program counter, skips, two cycles
// - Memory bit set forces bit j high
package crbf_pkg;
	localparam int PC_W       = 13;
	localparam int SP_W       = 3;
	localparam int STACK_N    = 8;
	localparam int PORT_N     = 6;
	localparam int RAM_AW     = 8;
	localparam logic [5:0] PORT_RESET  = 6'h3F;
	localparam logic [2:0] PORT_IDX_MAX = 3'h5;
	localparam logic [SP_W-1:0] SP_RESET = 3'h7;
	localparam int SAVE_W     = 27;
	typedef enum logic [2:0] {
		CRBF_OP_NONE, CRBF_OP_PORT_CLEAR, CRBF_OP_RET, CRBF_OP_RETI,
		CRBF_OP_RET_SKIP, CRBF_OP_BIT_SET, CRBF_OP_CARRY_CLEAR, CRBF_OP_CARRY_SET
	} crbf_op_t;
	typedef enum {CRBF_IDLE, CRBF_RET2} crbf_state_t;
endpackage : crbf_pkg

// [crbf_unit.sv]
// Execution unit for return, port bit clear, memory bit set and carry ops
`timescale 1ns/10ps
module crbf_unit
	import crbf_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                ce,
	input  wire crbf_op_t            op,
	input  wire logic                op_valid,
	input  wire logic [1:0]          bit_index,
	input  wire logic [2:0]          port_select,
	input  wire logic [RAM_AW-1:0]   data_pointer,
	input  wire logic [3:0]          ram_rdata,
	input  wire logic                push,
	input  wire logic [PC_W-1:0]     push_pc,
	input  wire logic                int_save,
	input  wire logic [SAVE_W-1:0]   int_state,
	output logic                     busy,
	output logic [PORT_N-1:0]        port_d,
	output logic                     carry_flag,
	output logic [PC_W-1:0]          program_counter,
	output logic                     pc_load,
	output logic                     skip_next,
	output logic [SP_W-1:0]          stack_level_pointer,
	output logic                     ram_we,
	output logic [RAM_AW-1:0]        ram_addr,
	output logic [3:0]               ram_wdata,
	output logic                     restore_valid,
	output logic [SAVE_W-1:0]        restore_state
);
	logic [PC_W-1:0]   return_stack [STACK_N];
	crbf_state_t       state, next_state;
	crbf_op_t          held_op, next_held_op;
	logic [PORT_N-1:0] next_port_d;
	logic              next_carry_flag, next_pc_load, next_skip_next, next_ram_we, next_restore_valid;
	logic [PC_W-1:0]   next_program_counter;
	logic [SP_W-1:0]   next_sp;
	logic [RAM_AW-1:0] next_ram_addr;
	logic [3:0]        next_ram_wdata;
	logic [SAVE_W-1:0] saved_state, next_saved_state;
	logic              taken;

	assign taken = ce && op_valid && state == CRBF_IDLE;
	assign busy = state == CRBF_RET2;

	always_comb
	begin
		next_state           = state;
		next_held_op         = held_op;
		next_port_d          = port_d;
		next_carry_flag      = carry_flag;
		next_program_counter = program_counter;
		next_pc_load         = 1'b0;
		next_skip_next       = 1'b0;
		next_sp              = stack_level_pointer;
		next_ram_we          = 1'b0;
		next_ram_addr        = ram_addr;
		next_ram_wdata       = ram_wdata;
		next_restore_valid   = 1'b0;
		next_saved_state     = saved_state;
		if (int_save)
			next_saved_state = int_state;
		if (push)
			next_sp = stack_level_pointer + 3'h1;
		unique case (state)
			CRBF_IDLE:
			begin
				if (taken)
				begin
					unique case (op)
						CRBF_OP_PORT_CLEAR:
							// Index above 5 is software's fault; it is ignored
							if (port_select <= PORT_IDX_MAX)
								next_port_d[port_select] = 1'b0;
						CRBF_OP_RET, CRBF_OP_RET_SKIP:
						begin
							next_state   = CRBF_RET2;
							next_held_op = op;
						end
						CRBF_OP_RETI:
						begin
							next_program_counter = return_stack[stack_level_pointer];
							next_pc_load         = 1'b1;
							next_sp              = stack_level_pointer - 3'h1;
							next_restore_valid   = 1'b1;
						end
						CRBF_OP_BIT_SET:
						begin
							next_ram_addr  = data_pointer;
							next_ram_wdata = ram_rdata | (4'h1 << bit_index);
							next_ram_we    = 1'b1;
						end
						CRBF_OP_CARRY_CLEAR: next_carry_flag = 1'b0;
						CRBF_OP_CARRY_SET:   next_carry_flag = 1'b1;
						default: ;
					endcase
				end
			end
			CRBF_RET2:
			begin
				if (ce)
				begin
					// Pop lands at the end of the second cycle
					next_program_counter = return_stack[stack_level_pointer];
					next_pc_load         = 1'b1;
					next_sp              = stack_level_pointer - 3'h1;
					next_skip_next       = held_op == CRBF_OP_RET_SKIP;
					next_state           = CRBF_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state               <= CRBF_IDLE;
			held_op             <= CRBF_OP_NONE;
			port_d              <= PORT_RESET;
			carry_flag          <= 1'b0;
			program_counter     <= '0;
			pc_load             <= 1'b0;
			skip_next           <= 1'b0;
			stack_level_pointer <= SP_RESET;
			ram_we              <= 1'b0;
			ram_addr            <= '0;
			ram_wdata           <= '0;
			restore_valid       <= 1'b0;
			saved_state         <= '0;
		end
		else if (ce)
		begin
			state               <= next_state;
			held_op             <= next_held_op;
			port_d              <= next_port_d;
			carry_flag          <= next_carry_flag;
			program_counter     <= next_program_counter;
			pc_load             <= next_pc_load;
			skip_next           <= next_skip_next;
			stack_level_pointer <= next_sp;
			ram_we              <= next_ram_we;
			ram_addr            <= next_ram_addr;
			ram_wdata           <= next_ram_wdata;
			restore_valid       <= next_restore_valid;
			saved_state         <= next_saved_state;
		end
	end

	assign restore_state = saved_state;

	// Stack storage has no reset; only the pointer matters at start
	always_ff @(posedge clock)
	begin
		if (ce && push)
			return_stack[stack_level_pointer + 3'h1] <= push_pc;
	end

	sequence s_ret_taken;
		taken && (op == CRBF_OP_RET || op == CRBF_OP_RET_SKIP);
	endsequence
	sequence s_pc_loaded;
		pc_load;
	endsequence
	sequence s_ret_plain;
		taken && op == CRBF_OP_RET;
	endsequence
	sequence s_ret_second;
		s_ret_taken ##1 ce;
	endsequence

	AST_PORT_CLEAR: assert property (@(posedge clock) disable iff (rst)
		taken && op == CRBF_OP_PORT_CLEAR && port_select <= PORT_IDX_MAX |=> !port_d[$past(port_select)])
		else $error("port bit not cleared");
	AST_RET_TWO: assert property (@(posedge clock) disable iff (rst)
		s_ret_taken ##1 ce |=> s_pc_loaded and !$past(pc_load))
		else $error("subroutine return not two cycles");
	AST_RETI_ONE: assert property (@(posedge clock) disable iff (rst)
		taken && op == CRBF_OP_RETI && !push |=> pc_load && stack_level_pointer == $past(stack_level_pointer) - 3'h1)
		else $error("interrupt return pop wrong");
	AST_RESTORE: assert property (@(posedge clock) disable iff (rst)
		taken && op == CRBF_OP_RETI && !int_save |=> restore_valid && restore_state == $past(saved_state))
		else $error("state not restored");
	// A frozen cycle holds the pulse, so it may repeat while ce is low
	AST_RESTORE_ONLY_RETI: assert property (@(posedge clock) disable iff (rst)
		restore_valid |-> ($past(taken) && $past(op) == CRBF_OP_RETI) || ($past(!ce) && $past(restore_valid)))
		else $error("spurious restore");
	AST_SKIP: assert property (@(posedge clock) disable iff (rst)
		taken && op == CRBF_OP_RET_SKIP ##1 ce |=> skip_next && pc_load)
		else $error("return skip missing");
	AST_BIT_SET: assert property (@(posedge clock) disable iff (rst)
		taken && op == CRBF_OP_BIT_SET |=> ram_we && ram_wdata[$past(bit_index)] && ram_addr == $past(data_pointer))
		else $error("memory bit not set");
	AST_CARRY: assert property (@(posedge clock) disable iff (rst)
		taken && (op == CRBF_OP_CARRY_SET || op == CRBF_OP_CARRY_CLEAR)
		|=> carry_flag == ($past(op) == CRBF_OP_CARRY_SET))
		else $error("carry flag wrong");
	// Port and carry change only on their own ops
	AST_PORT_ONLY_ON_CLEAR: assert property (@(posedge clock) disable iff (rst)
		!(taken && op == CRBF_OP_PORT_CLEAR) |=> $stable(port_d))
		else $error("port changed without clear");
	AST_PORT_IDX_GUARD: assert property (@(posedge clock) disable iff (rst)
		taken && op == CRBF_OP_PORT_CLEAR && port_select > PORT_IDX_MAX |=> $stable(port_d))
		else $error("port changed by bad index");
	AST_CARRY_HOLD: assert property (@(posedge clock) disable iff (rst)
		!(taken && (op == CRBF_OP_CARRY_SET || op == CRBF_OP_CARRY_CLEAR)) |=> $stable(carry_flag))
		else $error("carry changed without carry op");
	AST_RET_PC: assert property (@(posedge clock) disable iff (rst)
		s_ret_second |=> program_counter == $past(return_stack[stack_level_pointer]))
		else $error("return loaded wrong address");
	AST_RET_SP: assert property (@(posedge clock) disable iff (rst)
		s_ret_second ##0 !push |=> stack_level_pointer == $past(stack_level_pointer) - 3'h1)
		else $error("return pointer not decremented");
	AST_RET_NO_SKIP: assert property (@(posedge clock) disable iff (rst)
		s_ret_plain ##1 ce |=> !skip_next)
		else $error("plain return skipped");
	AST_BUSY_ONE: assert property (@(posedge clock) disable iff (rst)
		busy && ce |=> !busy)
		else $error("busy longer than one cycle");
	AST_RETI_NO_SKIP: assert property (@(posedge clock) disable iff (rst)
		taken && op == CRBF_OP_RETI |=> !skip_next && !busy)
		else $error("interrupt return skipped or stalled");
	// Read-modify-write must leave the other three bits alone
	AST_BIT_KEEP: assert property (@(posedge clock) disable iff (rst)
		taken && op == CRBF_OP_BIT_SET
		|=> (ram_wdata & ~(4'h1 << $past(bit_index))) == ($past(ram_rdata) & ~(4'h1 << $past(bit_index))))
		else $error("memory bit set disturbed other bits");
endmodule : crbf_unit

// [cpu_return_bit_flag_instructions_test.sv]
// Self-checking testbench for the return, bit and flag instruction unit
`timescale 1ns/10ps
module cpu_return_bit_flag_instructions_test
	import crbf_pkg::*;
;
	logic              clock, rst, ce, op_valid, push, int_save;
	crbf_op_t          op;
	logic [1:0]        bit_index;
	logic [2:0]        port_select;
	logic [RAM_AW-1:0] data_pointer;
	logic [3:0]        ram_rdata, ram_wdata;
	logic [PC_W-1:0]   push_pc, program_counter;
	logic [SAVE_W-1:0] int_state, restore_state;
	logic [PORT_N-1:0] port_d;
	logic [SP_W-1:0]   sp;
	logic [RAM_AW-1:0] ram_addr;
	logic              busy, carry_flag, pc_load, skip_next, ram_we, restore_valid;
	int                miscompares = 0;
	int                n_checks = 0;
	int                cycles = 0;
	crbf_unit dut (.clock(clock), .rst(rst), .ce(ce), .op(op), .op_valid(op_valid), .bit_index(bit_index),
		.port_select(port_select), .data_pointer(data_pointer), .ram_rdata(ram_rdata), .push(push),
		.push_pc(push_pc), .int_save(int_save), .int_state(int_state), .busy(busy), .port_d(port_d),
		.carry_flag(carry_flag), .program_counter(program_counter), .pc_load(pc_load),
		.skip_next(skip_next), .stack_level_pointer(sp), .ram_we(ram_we), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .restore_valid(restore_valid), .restore_state(restore_state));
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Whole run needs well under 200 cycles
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			results();
		end
	end
	task results;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Called at a falling edge; one idle cycle keeps op_valid from toggling twice at once
	task issue(input crbf_op_t o);
		@(negedge clock);
		op = o;
		op_valid = 1'b1;
		@(negedge clock);
		op_valid = 1'b0;
	endtask : issue
	task stack_push(input logic [PC_W-1:0] v);
		push = 1'b1;
		push_pc = v;
		@(negedge clock);
		push = 1'b0;
		chk(sp, 32'h0);
	endtask : stack_push
	task t_carry;
		issue(CRBF_OP_CARRY_SET);
		chk(carry_flag, 32'h1);
		ce = 1'b0;
		issue(CRBF_OP_CARRY_CLEAR);
		chk(carry_flag, 32'h1);
		ce = 1'b1;
		issue(CRBF_OP_CARRY_CLEAR);
		chk(carry_flag, 32'h0);
	endtask : t_carry
	task t_port;
		port_select = 3'h5;
		issue(CRBF_OP_PORT_CLEAR);
		chk(port_d, 32'h1F);
		port_select = 3'h6;
		issue(CRBF_OP_PORT_CLEAR);
		chk(port_d, 32'h1F);
		port_select = 3'h0;
		issue(CRBF_OP_PORT_CLEAR);
		chk(port_d, 32'h1E);
	endtask : t_port
	task t_bit;
		data_pointer = 8'h5A;
		ram_rdata = 4'h1;
		bit_index = 2'h3;
		issue(CRBF_OP_BIT_SET);
		chk({ram_we, ram_addr, ram_wdata}, 32'h15A9);
	endtask : t_bit
	task t_ret(input crbf_op_t o, input logic sk);
		stack_push(13'h0ABC);
		issue(o);
		chk({busy, pc_load}, 32'h2);
		@(negedge clock);
		chk({busy, pc_load, skip_next}, {31'h1, sk});
		chk({program_counter, sp}, {13'h0ABC, 3'h7});
	endtask : t_ret
	task t_reti;
		stack_push(13'h1357);
		int_save = 1'b1;
		int_state = 27'h5A5A5A5;
		@(negedge clock);
		int_save = 1'b0;
		issue(CRBF_OP_RETI);
		chk({pc_load, program_counter, sp}, {1'b1, 13'h1357, 3'h7});
		chk({restore_valid, restore_state}, 32'hDA5A5A5);
	endtask : t_reti
	initial
	begin
		{rst, ce, op_valid, push, int_save} = 5'h18;
		op = CRBF_OP_NONE;
		{bit_index, port_select, data_pointer, ram_rdata, push_pc, int_state} = '0;
		repeat (20) @(negedge clock);
		rst = 1'b0;
		chk({port_d, carry_flag, sp}, {PORT_RESET, 1'b0, SP_RESET});
		t_carry();
		t_port();
		t_bit();
		t_ret(CRBF_OP_RET, 1'b0);
		t_ret(CRBF_OP_RET_SKIP, 1'b1);
		t_reti();
		results();
	end
endmodule : cpu_return_bit_flag_instructions_test
